// ==== hw/dtrim_pkg.sv ====
// Register map, field positions and reset values of the DAC trim bank
package dtrim_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [7:0] OFS_CAL_FILTER_CTRL = 8'h0b;
  localparam logic [7:0] OFS_DITHER_OPTION_A = 8'h0c;
  localparam logic [7:0] OFS_DITHER_OPTION_B = 8'h0d;
  localparam logic [7:0] OFS_SPEEDUP_CTRL = 8'h0e;
  localparam logic [7:0] OFS_SHORT_DETECT_OFFSET_CTRL = 8'h0f;
  localparam logic [7:0] OFS_ELEMENT_SHUFFLE_DITHER_CTRL = 8'h10;
  localparam logic [7:0] OFS_DAC_PATH_SCALE_CTRL = 8'h11;
  localparam logic [7:0] OFS_PRIMARY_MODULATOR_COEFF_ZERO = 8'h12;
  localparam int NUM_REGS = 8;

  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_SHORT_DETECT_OFFSET_CTRL = 8'h10;
  localparam logic [7:0] RST_ELEMENT_SHUFFLE_DITHER_CTRL = 8'h20;

  // Field positions
  localparam int BIT_DITHER = 7;
  localparam int BIT_CAL_FILTER_BYPASS = 4;
  localparam int BIT_CAL_FILTER_FULL_SPAN = 3;
  localparam int BIT_CAL_FILTER_AVERAGING = 2;
  localparam int BIT_CAL_FINE_DISABLE = 1;
  localparam int BIT_CAL_POST_AVG_DISABLE = 0;
  localparam int BIT_CLOCK_LOSS_DETECT_SPEEDUP = 4;
  localparam int BIT_ANALOG_SEQUENCE_SPEEDUP = 0;
  localparam int BIT_SHORT_DETECT_OFF = 4;
  localparam int BIT_LATER_OFFSET_CANCEL_OFF = 0;
  localparam int SHUFFLE_LSB = 4;
  localparam int BIT_SECONDARY_DITHER_POLARITY = 0;
  localparam int BIT_LEFT_PATH_SCALE = 7;
  localparam int BIT_RIGHT_PATH_SCALE = 3;
  localparam int COEF_LEFT_LSB = 4;
  localparam int COEF_RIGHT_LSB = 0;

  // Calibration step schedule
  localparam logic [6:0] CAL_COARSE_STEPS_WITH_FINE = 7'd64;
  localparam logic [6:0] CAL_FINE_STEPS = 7'd32;
  localparam logic [6:0] CAL_COARSE_STEPS_ONLY = 7'd96;
  localparam logic [6:0] CAL_NO_STEPS = 7'd0;

  // Shuffle field encoding
  localparam logic [1:0] SHUF_NONE_A = 2'h0;
  localparam logic [1:0] SHUF_INTERNAL = 2'h1;
  localparam logic [1:0] SHUF_GLOBAL = 2'h2;
  localparam logic [1:0] SHUF_NONE_B = 2'h3;

  typedef enum logic [1:0] {
    SHUF_MODE_OFF,
    SHUF_MODE_INTERNAL,
    SHUF_MODE_GLOBAL
  } dtrim_shuffle_type;

  typedef enum logic [1:0] {
    BOND_RESERVED,
    BOND_105DB,
    BOND_110DB,
    BOND_OTHER
  } dtrim_bond_type;

endpackage

// ==== hw/dtrim_regs.sv ====
// DAC offset calibration and trim register bank
// Notes on behaviour
// - Filter bypass bit set skips the calibration front-end filter; clear uses it.
// - Span bit clear runs filter last half period; set runs whole period.
// - Filter type bit: clear majority decision, set averaging filter.
// - Fine disable clear: 64 coarse then 32 fine; set: 96 coarse only.
// - Post-average disable picks raw integrator output; clear picks averaged result.
// - Calibration register bit 7 dithers only with the reserved bond option.
// - Dither option A bit 7 applies only with the 105 dB bond option.
// - Dither option B bit 7 applies only with the 110 dB bond option.
// - Speed-up bits accelerate clock-loss detection (bit 4) and analog sequence (bit 0).
// - Short detect bit 4 is inverted enable, reset value 1.
// - Offset cancel suppress bit blocks every cancellation run after the first.
// - Shuffle field 0/3 none, 1 internal, 2 global; reset value 2.
// - Shuffle register bit 0 picks secondary DAC dither polarity, plus or minus.
// - Scale register bit 7 sets left secondary-to-primary scaling.
// - Scale register bit 3 sets right primary/secondary scaling.
// - Each coefficient-zero bit set forces that modulator coefficient to zero.
`timescale 1ns/1ps

module dtrim_regs
  import dtrim_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  output logic [DATA_W-1:0] regRdData,
  output logic regRdValid,
  // Bond option and calibration events
  input wire logic [1:0] bondOption,
  input wire logic offsetCancelRequest,
  // Calibration engine controls
  output logic calFilterBypass,
  output logic calFilterFullSpan,
  output logic calFilterAveraging,
  output logic [6:0] calCoarseSteps,
  output logic [6:0] calFineSteps,
  output logic calPostAvgDisable,
  // Dither, speed-up and protection
  output logic ditherActive,
  output logic clockLossDetectSpeedup,
  output logic analogSequenceSpeedup,
  output logic shortDetectEnable,
  output logic offsetCancelRun,
  // Element matching and scaling
  output logic shuffleInternal,
  output logic shuffleGlobal,
  output logic secondaryDitherNegative,
  output logic leftPathScale,
  output logic rightPathScale,
  // Modulator coefficient zero forcing, order a0 b1 b2 b3
  output logic [3:0] leftCoefZero,
  output logic [3:0] rightCoefZero
);

  logic [DATA_W-1:0] bank_r [NUM_REGS];
  logic [ADDR_W-1:0] regOfs [NUM_REGS];
  logic firstCancelDone_r;
  dtrim_shuffle_type shuffleMode;
  logic [1:0] shuffleField;

  assign regOfs[0] = OFS_CAL_FILTER_CTRL;
  assign regOfs[1] = OFS_DITHER_OPTION_A;
  assign regOfs[2] = OFS_DITHER_OPTION_B;
  assign regOfs[3] = OFS_SPEEDUP_CTRL;
  assign regOfs[4] = OFS_SHORT_DETECT_OFFSET_CTRL;
  assign regOfs[5] = OFS_ELEMENT_SHUFFLE_DITHER_CTRL;
  assign regOfs[6] = OFS_DAC_PATH_SCALE_CTRL;
  assign regOfs[7] = OFS_PRIMARY_MODULATOR_COEFF_ZERO;

  // Per-register storage
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          if (gi == 4) begin
            bank_r[gi] <= RST_SHORT_DETECT_OFFSET_CTRL;
          end else if (gi == 5) begin
            bank_r[gi] <= RST_ELEMENT_SHUFFLE_DITHER_CTRL;
          end else begin
            bank_r[gi] <= RST_ZERO;
          end
        end else if (regWrite && regAddr == regOfs[gi]) begin
          bank_r[gi] <= regWrData;
        end
      end
    end
  endgenerate

  // Read path, unmapped addresses read zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      regRdData <= RST_ZERO;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRead;
      if (regRead) begin
        regRdData <= RST_ZERO;
        for (int i = 0; i < NUM_REGS; i++) begin
          if (regAddr == regOfs[i]) begin
            regRdData <= bank_r[i];
          end
        end
      end
    end
  end

  // Calibration front end
  assign calFilterBypass = bank_r[0][BIT_CAL_FILTER_BYPASS];
  assign calFilterFullSpan = bank_r[0][BIT_CAL_FILTER_FULL_SPAN];
  assign calFilterAveraging = bank_r[0][BIT_CAL_FILTER_AVERAGING];
  assign calPostAvgDisable = bank_r[0][BIT_CAL_POST_AVG_DISABLE];

  always_comb begin
    if (bank_r[0][BIT_CAL_FINE_DISABLE]) begin
      calCoarseSteps = CAL_COARSE_STEPS_ONLY;
      calFineSteps = CAL_NO_STEPS;
    end else begin
      calCoarseSteps = CAL_COARSE_STEPS_WITH_FINE;
      calFineSteps = CAL_FINE_STEPS;
    end
  end

  // Dither gated by bond option
  always_comb begin
    case (dtrim_bond_type'(bondOption))
      BOND_RESERVED: ditherActive = bank_r[0][BIT_DITHER];
      BOND_105DB: ditherActive = bank_r[1][BIT_DITHER];
      BOND_110DB: ditherActive = bank_r[2][BIT_DITHER];
      default: ditherActive = 1'b0;
    endcase
  end

  assign clockLossDetectSpeedup = bank_r[3][BIT_CLOCK_LOSS_DETECT_SPEEDUP];
  assign analogSequenceSpeedup = bank_r[3][BIT_ANALOG_SEQUENCE_SPEEDUP];
  assign shortDetectEnable = ~bank_r[4][BIT_SHORT_DETECT_OFF];

  // First offset cancellation is always allowed
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      firstCancelDone_r <= 1'b0;
    end else if (offsetCancelRequest) begin
      firstCancelDone_r <= 1'b1;
    end
  end

  assign offsetCancelRun = offsetCancelRequest
    && !(firstCancelDone_r && bank_r[4][BIT_LATER_OFFSET_CANCEL_OFF]);

  // Element shuffle decode
  assign shuffleField = bank_r[5][SHUFFLE_LSB +: 2];
  always_comb begin
    case (shuffleField)
      SHUF_INTERNAL: shuffleMode = SHUF_MODE_INTERNAL;
      SHUF_GLOBAL: shuffleMode = SHUF_MODE_GLOBAL;
      default: shuffleMode = SHUF_MODE_OFF;
    endcase
  end
  assign shuffleInternal = (shuffleMode == SHUF_MODE_INTERNAL);
  assign shuffleGlobal = (shuffleMode == SHUF_MODE_GLOBAL);

  assign secondaryDitherNegative = bank_r[5][BIT_SECONDARY_DITHER_POLARITY];
  assign leftPathScale = bank_r[6][BIT_LEFT_PATH_SCALE];
  assign rightPathScale = bank_r[6][BIT_RIGHT_PATH_SCALE];

  // Coefficient zero forcing, a0 in bit 3 of each nibble
  genvar ci;
  generate
    for (ci = 0; ci < 4; ci++) begin : g_coef
      assign leftCoefZero[ci] = bank_r[7][COEF_LEFT_LSB + ci];
      assign rightCoefZero[ci] = bank_r[7][COEF_RIGHT_LSB + ci];
    end
  endgenerate

endmodule

// ==== test/dtrim_regs_properties.sv ====
// Checker for the DAC trim register bank ports
`timescale 1ns/1ps
module dtrim_regs_properties
  import dtrim_pkg::*;
(
  // Clock, reset and control port
  input wire logic clock, rst, regWrite, regRead, regRdValid,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData, regRdData,
  // Controls
  input wire logic [1:0] bondOption,
  input wire logic offsetCancelRequest, offsetCancelRun, calFilterBypass, calFilterFullSpan,
  input wire logic calFilterAveraging, ditherActive, shortDetectEnable,
  input wire logic shuffleInternal, shuffleGlobal,
  input wire logic [6:0] calCoarseSteps, calFineSteps
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_rdValid; regRdValid == $past(regRead); endproperty
  a_rdValid: assert property (p_rdValid) else $error("read valid pulse wrong");
  property p_unmapped; regRead && (regAddr < 8'h0b || regAddr > 8'h12) |=> regRdData == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_readBack; regWrite && regAddr inside {[8'h0b:8'h12]} ##1 regRead && !regWrite
    && regAddr == $past(regAddr) |=> regRdData == $past(regWrData, 2); endproperty
  a_readBack: assert property (p_readBack) else $error("read back differs");
  property p_bypass; regWrite && regAddr == OFS_CAL_FILTER_CTRL
    |=> calFilterBypass == $past(regWrData[4]); endproperty
  a_bypass: assert property (p_bypass) else $error("bypass wrong");
  property p_spanType; regWrite && regAddr == OFS_CAL_FILTER_CTRL
    |=> {calFilterFullSpan, calFilterAveraging} == $past(regWrData[3:2]); endproperty
  a_spanType: assert property (p_spanType) else $error("span or type wrong");
  property p_steps; regWrite && regAddr == OFS_CAL_FILTER_CTRL
    |=> calFineSteps == ($past(regWrData[1]) ? 7'h00 : 7'h20)
    && calCoarseSteps == ($past(regWrData[1]) ? 7'h60 : 7'h40); endproperty
  a_steps: assert property (p_steps) else $error("step schedule wrong");
  property p_dither; regWrite && regAddr == OFS_DITHER_OPTION_A && bondOption == 2'h1
    ##1 bondOption == 2'h1 |-> ditherActive == $past(regWrData[7]); endproperty
  a_dither: assert property (p_dither) else $error("dither wrong");
  property p_shortDet; regWrite && regAddr == OFS_SHORT_DETECT_OFFSET_CTRL
    |=> shortDetectEnable == !$past(regWrData[4]); endproperty
  a_shortDet: assert property (p_shortDet) else $error("short detect wrong");
  property p_shuffle; regWrite && regAddr == OFS_ELEMENT_SHUFFLE_DITHER_CTRL
    |=> {shuffleInternal, shuffleGlobal}
    == {$past(regWrData[5:4]) == 2'h1, $past(regWrData[5:4]) == 2'h2}; endproperty
  a_shuffle: assert property (p_shuffle) else $error("shuffle wrong");
  property p_cancel; offsetCancelRun |-> offsetCancelRequest; endproperty
  a_cancel: assert property (p_cancel) else $error("run without request");
  // Tracks the suppress bit and whether a request was already seen
  logic cancelSeen_r, cancelOff_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cancelSeen_r <= 1'b0;
      cancelOff_r <= RST_SHORT_DETECT_OFFSET_CTRL[BIT_LATER_OFFSET_CANCEL_OFF];
    end else begin
      if (offsetCancelRequest) begin
        cancelSeen_r <= 1'b1;
      end
      if (regWrite && regAddr == OFS_SHORT_DETECT_OFFSET_CTRL) begin
        cancelOff_r <= regWrData[BIT_LATER_OFFSET_CANCEL_OFF];
      end
    end
  end
  property p_cancelBlock; offsetCancelRequest
    |-> offsetCancelRun == !(cancelSeen_r && cancelOff_r); endproperty
  a_cancelBlock: assert property (p_cancelBlock) else $error("later cancel not blocked");
endmodule
bind dtrim_regs dtrim_regs_properties u_dtrim_regs_properties (.clock, .rst, .regWrite,
  .regRead, .regRdValid, .regAddr, .regWrData, .regRdData, .bondOption, .offsetCancelRequest,
  .offsetCancelRun, .calFilterBypass, .calFilterFullSpan, .calFilterAveraging, .ditherActive,
  .shortDetectEnable, .shuffleInternal, .shuffleGlobal, .calCoarseSteps, .calFineSteps);

// ==== test/dtrim_regs_tb.sv ====
// Self-checking bench for the DAC trim register bank
`timescale 1ns/1ps
module dtrim_regs_tb;
  import dtrim_pkg::*;
  logic clock = 0, rst = 1, regWrite = 0, regRead = 0, offsetCancelRequest = 0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
  logic [1:0] bondOption = 2'h0;
  logic regRdValid, calFilterBypass, calFilterFullSpan, calFilterAveraging, calPostAvgDisable;
  logic ditherActive, clockLossDetectSpeedup, analogSequenceSpeedup, shortDetectEnable;
  logic shuffleInternal, shuffleGlobal, secondaryDitherNegative, leftPathScale, rightPathScale;
  logic offsetCancelRun;
  logic [6:0] calCoarseSteps, calFineSteps;
  logic [3:0] leftCoefZero, rightCoefZero;
  logic [7:0] mdl [8];
  integer seed = 17, n_mismatch = 0, compares = 0, i;
  dtrim_regs u_dtrim_regs (.clock, .rst, .regWrite, .regRead, .regAddr, .regWrData,
    .regRdData, .regRdValid, .bondOption, .offsetCancelRequest, .calFilterBypass,
    .calFilterFullSpan, .calFilterAveraging, .calCoarseSteps, .calFineSteps,
    .calPostAvgDisable, .ditherActive, .clockLossDetectSpeedup, .analogSequenceSpeedup,
    .shortDetectEnable, .offsetCancelRun, .shuffleInternal, .shuffleGlobal,
    .secondaryDitherNegative, .leftPathScale, .rightPathScale, .leftCoefZero, .rightCoefZero);
  initial forever #2.5 clock = ~clock;
  task chk(input string nm, input logic [34:0] seen, input logic [34:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function logic [34:0] ex();
    logic [7:0] c;
    logic d;
    c = mdl[0];
    d = (bondOption == 2'h3) ? 1'b0 : mdl[bondOption][7];
    return {c[4], c[3], c[2], c[1] ? 7'h60 : 7'h40, c[1] ? 7'h00 : 7'h20, c[0], d, mdl[3][4],
      mdl[3][0], ~mdl[4][4], mdl[5][5:4] == 2'h1, mdl[5][5:4] == 2'h2, mdl[5][0], mdl[6][7],
      mdl[6][3], mdl[7]};
  endfunction
  task outs;
    logic [34:0] seen, want;
    seen = {calFilterBypass, calFilterFullSpan, calFilterAveraging, calCoarseSteps,
      calFineSteps, calPostAvgDisable, ditherActive, clockLossDetectSpeedup,
      analogSequenceSpeedup, shortDetectEnable, shuffleInternal, shuffleGlobal,
      secondaryDitherNegative, leftPathScale, rightPathScale, leftCoefZero, rightCoefZero};
    want = ex();
    chk("cal controls", 35'(seen[34:17]), 35'(want[34:17]));
    chk("dither speedup short", 35'(seen[16:13]), 35'(want[16:13]));
    chk("shuffle scale coef", 35'(seen[12:0]), 35'(want[12:0]));
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    regWrite = 1;
    regAddr = a;
    regWrData = d;
    @(posedge clock);
    #1 regWrite = 0;
    if (a >= 8'h0b && a <= 8'h12) mdl[a - 8'h0b] = d;
  endtask
  task rd(input logic [7:0] a);
    regRead = 1;
    regAddr = a;
    @(posedge clock);
    #1 regRead = 0;
    chk("valid", 35'(regRdValid), 35'h1);
    chk("rdata", 35'(regRdData), (a >= 8'h0b && a <= 8'h12) ? 35'(mdl[a - 8'h0b]) : 35'h0);
    @(posedge clock);
    #1;
  endtask
  task pulse(input logic exp);
    offsetCancelRequest = 1;
    #1 chk("cancel run", 35'(offsetCancelRun), 35'(exp));
    @(posedge clock);
    #1 offsetCancelRequest = 0;
    @(posedge clock);
    #1;
  endtask
  task doReset;
    rst = 1;
    foreach (mdl[k]) mdl[k] = 8'h00;
    mdl[4] = 8'h10;
    mdl[5] = 8'h20;
    repeat (3) @(posedge clock);
    #1 rst = 0;
    for (i = 8'h0a; i <= 8'h13; i++) rd(i[7:0]);
    outs;
    $display("reset values done");
  endtask
  task give_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #1;
    doReset;
    for (i = 0; i < 4; i++) begin
      bondOption = i[1:0];
      wr(8'h10, {2'h0, i[1:0], 4'h1});
      outs;
      rd(8'h10);
      wr(8'h0c, 8'h80);
      outs;
      rd(8'h0c);
    end
    $display("shuffle and bond corners done");
    for (i = 0; i < 60; i++) begin
      bondOption = 2'($random(seed));
      wr(8'h0b + 8'({$random(seed)} % 8), 8'($random(seed)));
      outs;
      rd(regAddr);
    end
    $display("random access done");
    doReset;
    wr(8'h0f, 8'h11);
    outs;
    pulse(1'b1);
    pulse(1'b0);
    wr(8'h0f, 8'h10);
    outs;
    pulse(1'b1);
    $display("offset cancel done");
    give_verdict;
  end
  initial begin
    #200000;
    n_mismatch++;
    give_verdict;
  end
endmodule
